//--- core/oamc_cfg.svh
`ifndef OAMC_CFG_SVH
`define OAMC_CFG_SVH

// Register offsets
`define OAMC_OFF_OUT_AUTO_DIS 8'h16
`define OAMC_OFF_FLAG_AUTO_DIS 8'h17
`define OAMC_OFF_MARGIN_EN 8'h18
`define OAMC_OFF_MUTE_LVL 8'h19
`define OAMC_OFF_STATUS 8'h1a

// Reset values
`define OAMC_RST_OUT_AUTO_DIS 8'hff
`define OAMC_RST_FLAG_AUTO_DIS 2'h2
`define OAMC_RST_MARGIN_EN 6'h00
`define OAMC_RST_MUTE_LVL 16'h5555

// Field positions
`define OAMC_FLAG_MASK_W 2
`define OAMC_MARGIN_W 6
`define OAMC_MARGIN_PAIR_A 0
`define OAMC_MARGIN_PAIR_B 1
`define OAMC_MARGIN_SINGLE_LO 2

// Margining needs a divide value above this
`define OAMC_MARGIN_MIN_DIV 8'h08

`endif

//--- core/oamc_pkg.sv
package oamc_pkg;
    typedef enum logic [1:0] {
        OAMC_LVL_BYPASS = 2'h0,
        OAMC_LVL_VCM = 2'h1,
        OAMC_LVL_HIGH = 2'h2,
        OAMC_LVL_RAIL = 2'h3
    } oamc_lvl_t;

    typedef enum logic [1:0] {
        OAMC_ST_RUN = 2'h1,
        OAMC_ST_MUTED = 2'h2
    } oamc_state_t;
endpackage

//--- core/oamc_top.sv
// Behaviour
// - Output channel n with auto-disable bit n set goes to its mute level while reference invalid.
// - Output channel with auto-disable bit clear keeps running always.
// - Flag pin 1 in clock mode with bit 1 set stops while invalid.
// - Flag pin 0 in clock mode with bit 0 set stops while invalid.
// - Flag pin not in clock mode ignores its bit, keeps normal function.
// - Flag pin clock with bit clear keeps toggling regardless of validity.
// - Margin bits 2..5 enable dividers 2..5 margining when divide above 8.
// - Margin bit 1 governs the divider shared by channels 2 and 3.
// - Margin bit 0 governs the divider shared by channels 0 and 1.
// - Mute level 0 bypass, 1 common mode, 2 high, 3 rail split.
`include "oamc_cfg.svh"

module oamc_top (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic CLK_EN,
    // Register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // Reference validity from detector (asynchronous)
    input wire logic REF_VALID,
    // Output clocks before gating, synthesizer domain
    input wire logic [7:0] OUT_CLK_IN,
    // Divide values of the six dividers
    input wire logic [47:0] DIV_VALUE,
    // Flag pins: normal function, clock selection and clock source
    input wire logic [1:0] FLAG_FUNC,
    input wire logic [1:0] FLAG_CLK_MODE,
    input wire logic [1:0] FLAG_CLK_IN,
    // Gated outputs
    output logic [7:0] OUT_CLK_P,
    output logic [7:0] OUT_CLK_N,
    output logic [7:0] OUT_MUTED,
    output logic [1:0] FLAG_PIN,
    // Margin enables to the dividers
    output logic [5:0] MARGIN_EN
);
    import oamc_pkg::*;

    typedef struct packed {
        logic [7:0] out_auto_dis;
        logic [1:0] flag_auto_dis;
        logic [5:0] margin_en;
        logic [15:0] mute_lvl;
        logic [1:0] valid_sync;
        oamc_state_t mute_state;
        logic [7:0] out_gate;
        logic [1:0] flag_gate;
        logic [7:0] out_p;
        logic [7:0] out_n;
        logic [1:0] flag_pin;
        logic [5:0] margin_q;
        logic [7:0] rdata;
    } oamc_state_s_t;

    oamc_state_s_t s;
    oamc_state_s_t next_s;

    function automatic logic out_p_val(input logic clk, input logic gate,
                                       input logic [1:0] lvl);
        logic v;
        v = clk;
        if (gate) begin
            case (oamc_lvl_t'(lvl))
                OAMC_LVL_BYPASS: v = clk;
                OAMC_LVL_VCM: v = 1'b0;
                OAMC_LVL_HIGH: v = 1'b1;
                OAMC_LVL_RAIL: v = 1'b1;
                default: v = 1'b0;
            endcase
        end
        return v;
    endfunction

    function automatic logic out_n_val(input logic clk, input logic gate,
                                       input logic [1:0] lvl);
        logic v;
        v = ~clk;
        if (gate) begin
            case (oamc_lvl_t'(lvl))
                OAMC_LVL_BYPASS: v = ~clk;
                OAMC_LVL_VCM: v = 1'b0;
                OAMC_LVL_HIGH: v = 1'b0;
                OAMC_LVL_RAIL: v = 1'b0;
                default: v = 1'b0;
            endcase
        end
        return v;
    endfunction

    logic invalid;
    logic [5:0] margin_ok;

    // Only the second stage of the synchroniser is looked at
    assign invalid = ~s.valid_sync[1];

    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_margin
            // Margining is meaningless at small divide values
            assign margin_ok[g] =
                DIV_VALUE[g*8 +: 8] > `OAMC_MARGIN_MIN_DIV;
        end
    endgenerate

    always_comb begin
        next_s = s;
        next_s.valid_sync = {s.valid_sync[0], REF_VALID};
        if (REG_WR) begin
            case (REG_ADDR)
                `OAMC_OFF_OUT_AUTO_DIS: next_s.out_auto_dis = REG_WDATA;
                `OAMC_OFF_FLAG_AUTO_DIS:
                    next_s.flag_auto_dis = REG_WDATA[1:0];
                `OAMC_OFF_MARGIN_EN: next_s.margin_en = REG_WDATA[5:0];
                `OAMC_OFF_MUTE_LVL: next_s.mute_lvl[7:0] = REG_WDATA;
                8'h1b: next_s.mute_lvl[15:8] = REG_WDATA;
                default: ;
            endcase
        end
        next_s.rdata = 8'h00;
        if (REG_RD) begin
            case (REG_ADDR)
                `OAMC_OFF_OUT_AUTO_DIS: next_s.rdata = s.out_auto_dis;
                `OAMC_OFF_FLAG_AUTO_DIS:
                    next_s.rdata = {6'h00, s.flag_auto_dis};
                `OAMC_OFF_MARGIN_EN: next_s.rdata = {2'h0, s.margin_en};
                `OAMC_OFF_MUTE_LVL: next_s.rdata = s.mute_lvl[7:0];
                8'h1b: next_s.rdata = s.mute_lvl[15:8];
                `OAMC_OFF_STATUS:
                    next_s.rdata = {5'h00, s.valid_sync[1],
                                    s.mute_state == OAMC_ST_MUTED,
                                    |s.out_gate};
                default: next_s.rdata = 8'h00;
            endcase
        end
        case (s.mute_state)
            OAMC_ST_RUN: if (invalid) next_s.mute_state = OAMC_ST_MUTED;
            OAMC_ST_MUTED: if (!invalid) next_s.mute_state = OAMC_ST_RUN;
            default: next_s.mute_state = OAMC_ST_RUN;
        endcase
        for (int i = 0; i < 8; i++) begin
            // Gate moves only while the clock is low, so no runt pulse
            if (!OUT_CLK_IN[i]) begin
                next_s.out_gate[i] = s.out_auto_dis[i] & invalid;
            end
            next_s.out_p[i] = out_p_val(OUT_CLK_IN[i], s.out_gate[i],
                                        s.mute_lvl[2*i +: 2]);
            next_s.out_n[i] = out_n_val(OUT_CLK_IN[i], s.out_gate[i],
                                        s.mute_lvl[2*i +: 2]);
        end
        for (int j = 0; j < 2; j++) begin
            if (!FLAG_CLK_IN[j]) begin
                next_s.flag_gate[j] = s.flag_auto_dis[j] & invalid;
            end
            if (FLAG_CLK_MODE[j]) begin
                next_s.flag_pin[j] = FLAG_CLK_IN[j] & ~s.flag_gate[j];
            end else begin
                next_s.flag_pin[j] = FLAG_FUNC[j];
            end
        end
        next_s.margin_q[`OAMC_MARGIN_PAIR_A] =
            s.margin_en[`OAMC_MARGIN_PAIR_A] & margin_ok[0];
        next_s.margin_q[`OAMC_MARGIN_PAIR_B] =
            s.margin_en[`OAMC_MARGIN_PAIR_B] & margin_ok[1];
        next_s.margin_q[5:`OAMC_MARGIN_SINGLE_LO] =
            s.margin_en[5:2] & margin_ok[5:2];
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            s.out_auto_dis <= `OAMC_RST_OUT_AUTO_DIS;
            s.flag_auto_dis <= `OAMC_RST_FLAG_AUTO_DIS;
            s.margin_en <= `OAMC_RST_MARGIN_EN;
            s.mute_lvl <= `OAMC_RST_MUTE_LVL;
            s.valid_sync <= 2'h0;
            s.mute_state <= OAMC_ST_RUN;
            s.out_gate <= 8'h00;
            s.flag_gate <= 2'h0;
            s.out_p <= 8'h00;
            s.out_n <= 8'h00;
            s.flag_pin <= 2'h0;
            s.margin_q <= 6'h00;
            s.rdata <= 8'h00;
        end else if (CLK_EN) begin
            s <= next_s;
        end
    end

    assign REG_RDATA = s.rdata;
    assign OUT_CLK_P = s.out_p;
    assign OUT_CLK_N = s.out_n;
    assign OUT_MUTED = s.out_gate;
    assign FLAG_PIN = s.flag_pin;
    assign MARGIN_EN = s.margin_q;
endmodule

//--- verif/oamc_top_asserts.sv
module oamc_top_asserts (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic CLK_EN,
    // Watched ports
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic REF_VALID,
    input wire logic [7:0] OUT_CLK_IN,
    input wire logic [47:0] DIV_VALUE,
    input wire logic [1:0] FLAG_FUNC,
    input wire logic [1:0] FLAG_CLK_MODE,
    input wire logic [7:0] OUT_MUTED,
    input wire logic [1:0] FLAG_PIN,
    input wire logic [5:0] MARGIN_EN
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0] div_gt;
    logic ok;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    // A frozen or resetting cycle breaks every one-cycle relation below
    always_ff @(posedge CLK_SYS) begin
        for (int i = 0; i < 6; i++) begin
            div_gt[i] <= DIV_VALUE[8*i +: 8] > 8'h08;
        end
        ok <= RST_B && CLK_EN;
    end
    property p_rdata_idle;
        ok && !$past(REG_RD) |-> REG_RDATA == 8'h00;
    endproperty
    // Frozen cycles hold the enables while the divide values move on
    property p_margin_a;
        ok && MARGIN_EN[0] |-> div_gt[0];
    endproperty
    property p_margin_b;
        ok && MARGIN_EN[1] |-> div_gt[1];
    endproperty
    property p_margin_s;
        ok |-> (MARGIN_EN[5:2] & ~div_gt[5:2]) == 4'h0;
    endproperty
    property p_flag0;
        ok && !$past(FLAG_CLK_MODE[0]) |-> FLAG_PIN[0] == $past(FLAG_FUNC[0]);
    endproperty
    property p_flag1;
        ok && !$past(FLAG_CLK_MODE[1]) |-> FLAG_PIN[1] == $past(FLAG_FUNC[1]);
    endproperty
    property p_gate;
        ok |-> ($past(OUT_CLK_IN) & (OUT_MUTED ^ $past(OUT_MUTED))) == 8'h00;
    endproperty
    property p_cause;
        $past(RST_B, 4) && (OUT_MUTED & ~$past(OUT_MUTED)) != 8'h00
            |-> !$past(REF_VALID, 3);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("stray data");
    a_margin_a: assert property (p_margin_a) else $error("pair a");
    a_margin_b: assert property (p_margin_b) else $error("pair b");
    a_margin_s: assert property (p_margin_s) else $error("single");
    a_flag0: assert property (p_flag0) else $error("flag pin 0");
    a_flag1: assert property (p_flag1) else $error("flag pin 1");
    a_gate: assert property (p_gate) else $error("gate in high");
    a_cause: assert property (p_cause) else $error("mute cause");
    c_mute: cover property ((OUT_MUTED & ~$past(OUT_MUTED)) != 8'h00);
    c_margin: cover property (MARGIN_EN != 6'h00);
    c_read: cover property (REG_RD ##1 REG_RDATA != 8'h00);
endmodule
bind oamc_top oamc_top_asserts u_chk (.*);

//--- verif/oamc_load.sv
module oamc_load (
    // Received clock pins
    input wire logic [9:0] p,
    // Window control and result
    input wire logic clr,
    output logic [9:0] moving
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [9:0] last;
    // Unclocked, as a real load would see any edge at all
    always @(p or posedge clr) begin
        if (clr) moving = 10'h000;
        else moving = moving | (p ^ last);
        last = p;
    end
endmodule

//--- verif/oamc_top_tb_top.sv
module oamc_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst_b = 0, en = 1, wr = 0, rd = 0, rv = 1, clr = 0;
    logic [7:0] addr = 0, wd = 0, rdata, oin = 0, op, on, om;
    logic [47:0] dv = 0;
    logic [1:0] fn = 0, fm = 0, fk = 0, fp;
    logic [5:0] me;
    logic [9:0] mv;
    int err_total = 0, n_compared = 0;
    oamc_top u_dut (.CLK_SYS(clk), .RST_B(rst_b), .CLK_EN(en),
        .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd),
        .REG_RDATA(rdata), .REF_VALID(rv), .OUT_CLK_IN(oin),
        .DIV_VALUE(dv), .FLAG_FUNC(fn), .FLAG_CLK_MODE(fm),
        .FLAG_CLK_IN(fk), .OUT_CLK_P(op), .OUT_CLK_N(on),
        .OUT_MUTED(om), .FLAG_PIN(fp), .MARGIN_EN(me));
    oamc_load u_load (.p({fp, op}), .clr(clr), .moving(mv));
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        oin <= ~oin;
        fk <= ~fk;
    end
    task automatic chk(input logic [9:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
            err_total++;
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    task automatic rd_reg(input logic [7:0] a, e);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 chk(rdata, e);
    endtask
    // Long enough for the two-flop sync, a low phase and the output flop
    task automatic phase(input logic v, input logic [9:0] e);
        rv <= v;
        repeat (8) @(posedge clk);
        clr = 1;
        #1 clr = 0;
        repeat (8) @(posedge clk);
        #1 chk(mv, e);
    endtask
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        results();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1;
        rd_reg(8'h16, 8'hff);
        rd_reg(8'h17, 8'h02);
        rd_reg(8'h18, 8'h00);
        rd_reg(8'h19, 8'h55);
        rd_reg(8'h1b, 8'h55);
        rd_reg(8'h1c, 8'h00);
        $display("test reset done");
        dv <= {8'h00, 8'hff, 8'h08, 8'h09, 8'h08, 8'h09};
        wr_reg(8'h18, 8'hff);
        rd_reg(8'h18, 8'h3f);
        chk(me, 6'h15);
        dv[15:8] <= 8'h09;
        repeat (2) @(posedge clk);
        #1 chk(me, 6'h17);
        $display("test margin done");
        wr_reg(8'h16, 8'h0f);
        wr_reg(8'h19, 8'he4);
        wr_reg(8'h17, 8'h03);
        fm <= 2'b01;
        fn <= 2'b10;
        phase(0, 10'h0f1);
        chk(om[7:1], 7'h07);
        chk({fp, op[3:1], on[3:1]}, 8'b10_110_000);
        rd_reg(8'h1a, 8'h03);
        phase(1, 10'h1ff);
        fm <= 2'b11;
        wr_reg(8'h17, 8'h02);
        wr_reg(8'h16, 8'h00);
        phase(0, 10'h1ff);
        chk(om, 8'h00);
        rv <= 1;
        $display("test mute done");
        results();
    end
endmodule
